/* hw/mic_defines.svh */
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ============================================================
// Register map, one aligned 32-bit word each.
`define MIC_OFF_TIMER_CTRL 8'h00
`define MIC_OFF_PORT1_FLAG 8'h04
`define MIC_OFF_ENABLE 8'h08
`define MIC_OFF_PRIORITY 8'h0c
`define MIC_OFF_STATUS 8'h10

// ============================================================
// Field positions.
`define MIC_BIT_EXT0_TRIG 0
`define MIC_BIT_EXT0_PEND 1
`define MIC_BIT_EXT1_TRIG 2
`define MIC_BIT_EXT1_PEND 3
`define MIC_BIT_EXT4_PEND 4
`define MIC_BIT_GLOBAL_EN 31

// ============================================================
// Arbitration positions of shared or special sources.
`define MIC_POS_EXT0 0
`define MIC_POS_EXT1 2
`define MIC_POS_SERIAL 4
`define MIC_POS_TIMER2 5
`define MIC_POS_COUNTER 9
`define MIC_POS_CMP0_FALL 10
`define MIC_POS_CMP0_RISE 11
`define MIC_POS_EXT4 16
`define MIC_POS_UNUSED 20

// ============================================================
// Vectors, reset values and timing.
`define MIC_VEC_RESET 16'h0000
`define MIC_VEC_BASE 16'h0003
`define MIC_CALL_CYCLES 3'h4
`define MIC_RST_WORD 32'h0000_0000
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_DECERR 2'h3

`endif

/* hw/mic_pkg.sv */
package mic_pkg;

    // Controller sequencing: waiting for a grant, or running the call.
    typedef enum logic {MIC_ST_IDLE, MIC_ST_CALL} mic_state_type;

    // One bit per arbitration position.
    typedef logic [21:0] mic_src_type;

endpackage : mic_pkg

/* hw/mic_pin_sync.sv */
// ============================================================
// Pin synchroniser with falling-edge detection.
module mic_pin_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_n,
    output logic level_n,
    output logic fall
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic prev_reg;
    logic prev_next;

    // Only the second and third stages are read; the first may be metastable.
    always_comb begin
        meta_next = pin_n;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // Idle pins sit high, so reset to high avoids a false edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // A high sample followed by a low one is a falling edge.
    assign level_n = sync_reg;
    assign fall = prev_reg & ~sync_reg;

endmodule : mic_pin_sync

/* hw/mic_irq_ctrl.sv */
// How it works
// - Inputs 0 and 1 are active low, level or falling edge per select bit.
// - Edge-mode pending flag of input 0 or 1 clears when the call completes.
// - Level-mode pending flag of input 0 or 1 follows the inverted pin.
// - Inputs 4 to 7 are active low, edge only, flags in bits 4-7.
// - Reset vectors to 0x0000; sources vector from 0x0003 in steps of eight.
// - Sources with several flags request their shared vector when any is set.
// - Timer 2 overflow or external flag requests position 5.
// - Comparator falling and rising edges are separate sources and vectors.
// - Each source has one priority bit choosing low or high level.
// - High requests preempt low routines; nothing preempts a high routine.
// - All priority bits select low after reset.
// - High level wins first, then the lowest arbitration position.
// - Pending requests are sampled and arbitrated on every clock.
// - Fastest response is one detect clock plus four call clocks.
// - After a return, at least one more instruction completes before a call.
// - Worst response follows from waiting for the instruction in progress.
// - Equal or lower requests wait for return and one more instruction.
// - Individual enables count only while the global enable is set.
// - Flags set regardless of enable; disabled flags are ignored.
// - A flag still set after return requests again at once.
// - Software writing one to a pending flag requests like hardware; in level mode the pin overrides it for inputs 0 and 1.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "mic_defines.svh"

module mic_irq_ctrl #(
    parameter int NUM_CAPTURE = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_irq0_n,
    input wire logic ext_irq1_n,
    input wire logic [3:0] ext_irq_hi_n,
    input wire logic [21:0] periph_flags,
    input wire logic serial_rx_flag,
    input wire logic serial_tx_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic counter_array_overflow_flag,
    input wire logic [NUM_CAPTURE-1:0] capture_module_flag,
    input wire logic cpu_insn_done,
    input wire logic cpu_return_from_irq,
    output logic long_vector_call,
    output logic vector_call_done,
    output logic [15:0] vector_addr,
    output logic [1:0] active_level
);
    // ============================================================
    // Pin synchronisers for the six external inputs.
    logic [5:0] pin_n;
    logic [5:0] pin_lvl_n;
    logic [5:0] pin_fall;

    assign pin_n = {ext_irq_hi_n, ext_irq1_n, ext_irq0_n};

    for (genvar g = 0; g < 6; g++) begin : g_pin
        mic_pin_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_n(pin_n[g]),
            .level_n(pin_lvl_n[g]),
            .fall(pin_fall[g])
        );
    end

    // ============================================================
    // AXI4-Lite slave.
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] waddr_reg, waddr_next;
    logic [31:0] wdat_reg, wdat_next;
    logic [3:0] wstb_reg, wstb_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] status_word;

    // Core state, declared here because the read mux shows it.
    logic [1:0] trig_reg, trig_next;
    logic [1:0] ext_pend_reg, ext_pend_next;
    logic [3:0] p1_pend_reg, p1_pend_next;
    logic [21:0] en_reg, en_next;
    logic gie_reg, gie_next;
    mic_pkg::mic_src_type prio_reg, prio_next;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address and data are taken in either order; the write lands in
    // the cycle the second arrives, and both stall until bready.
    always_comb begin
        aw_hold_next = aw_hold_reg | (awvalid & awready_reg);
        w_hold_next = w_hold_reg | (wvalid & wready_reg);
        waddr_next = (awvalid & awready_reg) ? awaddr : waddr_reg;
        wdat_next = (wvalid & wready_reg) ? wdata : wdat_reg;
        wstb_next = (wvalid & wready_reg) ? wstrb : wstb_reg;
        bvalid_next = bvalid_reg & ~bready;
        bresp_next = bresp_reg;
        wr_en = aw_hold_next & w_hold_next & ~bvalid_reg;
        wr_addr = waddr_next;
        wr_data = wdat_next;
        wr_strb = wstb_next;
        if (wr_en) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_addr <= `MIC_OFF_PRIORITY &&
                          wr_addr[1:0] == 2'h0) ?
                         `MIC_RESP_OKAY : `MIC_RESP_DECERR;
        end
        awready_next = ~aw_hold_next & ~bvalid_next;
        wready_next = ~w_hold_next & ~bvalid_next;
        rvalid_next = rvalid_reg & ~rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid & arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `MIC_RESP_OKAY;
            case (araddr)
                `MIC_OFF_TIMER_CTRL: rdata_next = {28'h0, ext_pend_reg[1],
                    trig_reg[1], ext_pend_reg[0], trig_reg[0]};
                `MIC_OFF_PORT1_FLAG: rdata_next = {24'h0, p1_pend_reg, 4'h0};
                `MIC_OFF_ENABLE: rdata_next = {gie_reg, 9'h0, en_reg};
                `MIC_OFF_PRIORITY: rdata_next = {10'h0, prio_reg};
                `MIC_OFF_STATUS: rdata_next = status_word;
                default: begin
                    rdata_next = `MIC_RST_WORD;
                    rresp_next = `MIC_RESP_DECERR;
                end
            endcase
        end
        arready_next = ~rvalid_next;
    end

    // Registers of the bus slave.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdat_reg <= `MIC_RST_WORD;
            wstb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `MIC_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= `MIC_RST_WORD;
            rresp_reg <= `MIC_RESP_OKAY;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            waddr_reg <= waddr_next;
            wdat_reg <= wdat_next;
            wstb_reg <= wstb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ============================================================
    // Flags, arbitration and the call sequence.
    mic_pkg::mic_state_type state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [1:0] active_reg, active_next;
    logic hold_reg, hold_next;
    logic win_valid_reg, win_valid_next, win_high_reg, win_high_next;
    logic [4:0] win_pos_reg, win_pos_next, call_pos_reg, call_pos_next;
    logic call_high_reg, call_high_next;
    logic busy_reg, busy_next, done_reg, done_next;
    logic [15:0] vec_reg, vec_next;
    logic [31:0] wmerged;
    mic_pkg::mic_src_type src;
    mic_pkg::mic_src_type req;
    logic start, finish;

    assign status_word = {18'h0, busy_reg, hold_reg, active_reg,
                          win_high_reg, win_valid_reg, 3'h0, win_pos_reg};

    always_comb begin
        trig_next = trig_reg;
        ext_pend_next = ext_pend_reg;
        p1_pend_next = p1_pend_reg;
        en_next = en_reg;
        gie_next = gie_reg;
        prio_next = prio_reg;
        wmerged = merge(`MIC_RST_WORD, wr_data, wr_strb);
        // Software writes: a one in a pending bit raises a request, except input 0 or 1 in level mode.
        if (wr_en && wr_strb[0] && wr_addr == `MIC_OFF_TIMER_CTRL) begin
            trig_next = {wr_data[`MIC_BIT_EXT1_TRIG],
                         wr_data[`MIC_BIT_EXT0_TRIG]};
            ext_pend_next = {wr_data[`MIC_BIT_EXT1_PEND],
                             wr_data[`MIC_BIT_EXT0_PEND]};
        end
        if (wr_en && wr_strb[0] && wr_addr == `MIC_OFF_PORT1_FLAG) begin
            p1_pend_next = wr_data[`MIC_BIT_EXT4_PEND +: 4];
        end
        if (wr_en && wr_addr == `MIC_OFF_ENABLE) begin
            wmerged = merge({gie_reg, 9'h0, en_reg}, wr_data, wr_strb);
            en_next = wmerged[21:0];
            en_next[`MIC_POS_UNUSED] = 1'b0;
            gie_next = wmerged[`MIC_BIT_GLOBAL_EN];
        end
        if (wr_en && wr_addr == `MIC_OFF_PRIORITY) begin
            wmerged = merge({10'h0, prio_reg}, wr_data, wr_strb);
            prio_next = wmerged[21:0];
        end
        // Hardware clear at the end of the call, for edge mode only.
        if (finish && call_pos_reg == 5'(`MIC_POS_EXT0) && trig_reg[0]) begin
            ext_pend_next[0] = 1'b0;
        end
        if (finish && call_pos_reg == 5'(`MIC_POS_EXT1) && trig_reg[1]) begin
            ext_pend_next[1] = 1'b0;
        end
        if (finish && call_pos_reg[4:2] == 3'h4) begin
            p1_pend_next[call_pos_reg[1:0]] = 1'b0;
        end
        // Edges set flags last, so a set beats any clear.
        for (int i = 0; i < 2; i++) begin
            if (!trig_reg[i]) begin
                ext_pend_next[i] = ~pin_lvl_n[i];
            end else if (pin_fall[i]) begin
                ext_pend_next[i] = 1'b1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (pin_fall[i+2]) begin
                p1_pend_next[i] = 1'b1;
            end
        end
    end

    // Pending set is independent of the enables; gating is later.
    always_comb begin
        src = periph_flags;
        src[`MIC_POS_EXT0] = ext_pend_reg[0];
        src[`MIC_POS_EXT1] = ext_pend_reg[1];
        src[`MIC_POS_SERIAL] = serial_rx_flag | serial_tx_flag;
        src[`MIC_POS_TIMER2] = timer2_overflow_flag |
                               timer2_external_flag;
        src[`MIC_POS_COUNTER] = counter_array_overflow_flag |
                                (|capture_module_flag);
        src[`MIC_POS_EXT4 +: 4] = p1_pend_reg;
        src[`MIC_POS_UNUSED] = 1'b0;
        req = gie_reg ? (src & en_reg) : '0;
    end

    // Resolve every cycle; the downward scan leaves the lowest
    // position, high level first, and active levels gate eligibility.
    always_comb begin
        win_valid_next = 1'b0;
        win_high_next = 1'b0;
        win_pos_next = 5'h00;
        for (int i = 21; i >= 0; i--) begin
            if (req[i] && !prio_reg[i] && active_reg == 2'h0) begin
                win_valid_next = 1'b1;
                win_pos_next = 5'(i);
            end
        end
        for (int i = 21; i >= 0; i--) begin
            if (req[i] && prio_reg[i] && !active_reg[1]) begin
                win_valid_next = 1'b1;
                win_high_next = 1'b1;
                win_pos_next = 5'(i);
            end
        end
    end

    // The call starts only at an instruction boundary; after a return
    // one further instruction must complete first, which bounds the
    // worst response. The cycle after a call is skipped because the
    // registered winner still reflects the old active level.
    assign start = state_reg == mic_pkg::MIC_ST_IDLE && win_valid_reg &&
                   cpu_insn_done && !cpu_return_from_irq && !hold_reg &&
                   !done_reg;
    assign finish = state_reg == mic_pkg::MIC_ST_CALL && cnt_reg == 3'h0;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        call_pos_next = call_pos_reg;
        call_high_next = call_high_reg;
        active_next = active_reg;
        vec_next = vec_reg;
        done_next = 1'b0;
        hold_next = hold_reg;
        if (cpu_return_from_irq) begin
            hold_next = 1'b1;
            active_next = active_reg[1] ? {1'b0, active_reg[0]} : 2'h0;
        end else if (cpu_insn_done) begin
            hold_next = 1'b0;
        end
        case (state_reg)
            mic_pkg::MIC_ST_IDLE: begin
                if (start) begin
                    state_next = mic_pkg::MIC_ST_CALL;
                    cnt_next = `MIC_CALL_CYCLES - 3'h1;
                    call_pos_next = win_pos_reg;
                    call_high_next = win_high_reg;
                end
            end
            mic_pkg::MIC_ST_CALL: begin
                cnt_next = cnt_reg - 3'h1;
                if (finish) begin
                    state_next = mic_pkg::MIC_ST_IDLE;
                    done_next = 1'b1;
                    vec_next = `MIC_VEC_BASE +
                               {8'h00, call_pos_reg, 3'h0};
                    if (call_high_reg) begin
                        active_next[1] = 1'b1;
                    end else begin
                        active_next[0] = 1'b1;
                    end
                end
            end
            default: state_next = mic_pkg::MIC_ST_IDLE;
        endcase
        busy_next = state_next == mic_pkg::MIC_ST_CALL;
    end

    // Core registers; priorities reset to low and the vector to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_reg <= 2'h0;
            ext_pend_reg <= 2'h0;
            p1_pend_reg <= 4'h0;
            en_reg <= 22'h0;
            gie_reg <= 1'b0;
            prio_reg <= 22'h0;
            state_reg <= mic_pkg::MIC_ST_IDLE;
            cnt_reg <= 3'h0;
            active_reg <= 2'h0;
            hold_reg <= 1'b0;
            win_valid_reg <= 1'b0;
            win_high_reg <= 1'b0;
            win_pos_reg <= 5'h00;
            call_pos_reg <= 5'h00;
            call_high_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            vec_reg <= `MIC_VEC_RESET;
        end else begin
            trig_reg <= trig_next;
            ext_pend_reg <= ext_pend_next;
            p1_pend_reg <= p1_pend_next;
            en_reg <= en_next;
            gie_reg <= gie_next;
            prio_reg <= prio_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            active_reg <= active_next;
            hold_reg <= hold_next;
            win_valid_reg <= win_valid_next;
            win_high_reg <= win_high_next;
            win_pos_reg <= win_pos_next;
            call_pos_reg <= call_pos_next;
            call_high_reg <= call_high_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            vec_reg <= vec_next;
        end
    end

    assign long_vector_call = busy_reg;
    assign vector_call_done = done_reg;
    assign vector_addr = vec_reg;
    assign active_level = active_reg;

    // ============================================================
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence call_run;
        busy_reg [*4] ##1 (done_reg && !busy_reg);
    endsequence

    AST_LEVEL_MIRROR: assert property (!trig_reg[0] && !trig_next[0] |=>
        ext_pend_reg[0] == !$past(pin_lvl_n[0]))
        else $error("level flag does not follow pin");
    AST_EDGE_SET: assert property (trig_reg[1] && pin_fall[1] |=>
        ext_pend_reg[1]) else $error("edge lost");
    AST_EDGE_CLEAR: assert property (finish && call_pos_reg == 5'h00 &&
        trig_reg[0] && !pin_fall[0] && !wr_en |=> !ext_pend_reg[0])
        else $error("edge flag not cleared at call");
    AST_CALL_LEN: assert property (start |=> call_run)
        else $error("call not four cycles");
    AST_NO_PREEMPT_HIGH: assert property (active_reg[1] |->
        !start)
        else $error("high routine preempted");
    AST_GLOBAL_OFF: assert property ($past(!gie_reg) && !gie_reg |->
        !win_valid_reg) else $error("request while globally off");
    AST_RETURN_FROM_IRQ_ONE: assert property (cpu_return_from_irq ##1
        !cpu_insn_done |=> !start) else $error("call before insn");
    AST_PRIO_RESET: assert property (disable iff (1'b0)
        !aresetn |=> prio_reg == 22'h0) else $error("priority not low");
    AST_VEC_RANGE: assert property (done_reg |-> vec_reg[2:0] == 3'h3 &&
        vec_reg <= 16'h00ab && vec_reg != 16'h00a3)
        else $error("bad vector");
    AST_HIGH_FIRST: assert property (|(req & prio_reg) && !active_reg[1]
        |=> win_high_reg) else $error("low granted over high");

endmodule : mic_irq_ctrl

/* testbench/mic_cpu_model.sv */
// ============================================================
// CPU model: retires one instruction each cycle outside a call or a return.
module mic_cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic long_vector_call,
    input wire logic ret_req,
    output logic cpu_insn_done,
    output logic cpu_return_from_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // The return cycle retires nothing else, so the next one is seen.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_insn_done <= 1'b0;
            cpu_return_from_irq <= 1'b0;
        end else begin
            cpu_insn_done <= !long_vector_call && !ret_req;
            cpu_return_from_irq <= ret_req;
        end
    end
endmodule : mic_cpu_model

/* testbench/tb_top.sv */
// ============================================================
// Bench for the interrupt controller.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
$display("wrong value at %0t: %h not %h", $time, g, e); end end
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ext_irq0_n, ext_irq1_n, ret_req;
    logic serial_rx_flag, serial_tx_flag, timer2_overflow_flag;
    logic timer2_external_flag, counter_array_overflow_flag, cpu_insn_done;
    logic cpu_return_from_irq, long_vector_call, vector_call_done;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, ext_irq_hi_n;
    logic [1:0] bresp, rresp, r, active_level;
    logic [21:0] periph_flags;
    logic [4:0] capture_module_flag;
    logic [15:0] vector_addr;
    int mismatches, n_compared;
    mic_irq_ctrl u_mic_irq_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_irq0_n,
        .ext_irq1_n, .ext_irq_hi_n, .periph_flags, .serial_rx_flag,
        .serial_tx_flag, .timer2_overflow_flag, .timer2_external_flag,
        .counter_array_overflow_flag, .capture_module_flag, .cpu_insn_done,
        .cpu_return_from_irq, .long_vector_call, .vector_call_done,
        .vector_addr, .active_level);
    mic_cpu_model u_mic_cpu_model (.aclk, .aresetn, .long_vector_call,
        .ret_req, .cpu_insn_done, .cpu_return_from_irq);
    // Free-running system clock.
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // A spent bound is a hang: count it and close the run.
    task automatic tmo(input int i);
        if (i >= 99) begin
            mismatches++;
            end_of_test();
        end
    endtask : tmo
    // Outputs are read at the edge, before that edge's updates land.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1;
        wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        tmo(i);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata; r = rresp; rready <= 1'b0;
        tmo(i);
        @(posedge aclk);
    endtask : rd
    // Waits for one vectoring call and measures its length.
    task automatic wait_call(input logic [15:0] exp);
        int i, n;
        n = 0;
        for (i = 0; i < 99; i++) begin
            @(posedge aclk);
            if (long_vector_call === 1'b1) n++;
            if (vector_call_done === 1'b1) break;
        end
        tmo(i);
        `CHK(vector_addr, exp)
        `CHK(n, 4)
    endtask : wait_call
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge aclk);
            `CHK(long_vector_call, 1'b0)
        end
    endtask : idle
    task automatic ret(input logic [1:0] lvl);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK(active_level, lvl)
    endtask : ret
    task automatic t_reset();
        rd(8'h0c);
        `CHK(d, 32'h0000_0000)
        rd(8'h14);
        `CHK(r, 2'h3)
    endtask : t_reset
    task automatic t_edge();
        wr(8'h00, 32'h0000_0001);
        wr(8'h08, 32'h8000_0001);
        ext_irq0_n <= 1'b0;
        repeat (3) @(posedge aclk);
        ext_irq0_n <= 1'b1;
        wait_call(16'h0003);
        rd(8'h00);
        `CHK(d, 32'h0000_0001)
        ret(2'h0);
    endtask : t_edge
    // Level source holds its pin low past recognition, then once too long.
    task automatic t_level();
        wr(8'h00, 32'h0000_0000);
        wr(8'h08, 32'h0000_0004);
        ext_irq1_n <= 1'b0;
        idle(20);
        rd(8'h00);
        `CHK(d, 32'h0000_0008)
        wr(8'h08, 32'h8000_0004);
        wait_call(16'h0013);
        ret(2'h0);
        wait_call(16'h0013);
        ext_irq1_n <= 1'b1;
        idle(5);
        ret(2'h0);
        idle(20);
    endtask : t_level
    task automatic t_arb();
        wr(8'h0c, 32'h0004_0000);
        wr(8'h08, 32'h800f_0000);
        wr(8'h04, 32'h0000_00f0);
        `CHK(r, 2'h0)
        wait_call(16'h0093);
        ret(2'h0);
        wait_call(16'h0083);
        wr(8'h0c, 32'h0008_0000);
        wait_call(16'h009b);
        ret(2'h1);
        ret(2'h0);
        wait_call(16'h008b);
        ret(2'h0);
    endtask : t_arb
    task automatic t_shared();
        logic [15:0] vec [5];
        vec = '{16'h0023, 16'h002b, 16'h004b, 16'h0053, 16'h005b};
        wr(8'h08, 32'h8000_0e30);
        for (int k = 0; k < 5; k++) begin
            {periph_flags[11:10], capture_module_flag[4],
                timer2_external_flag, serial_tx_flag} <= 5'b00001 << k;
            wait_call(vec[k]);
            {periph_flags[11:10], capture_module_flag[4],
                timer2_external_flag, serial_tx_flag} <= 5'h00;
            ret(2'h0);
        end
    endtask : t_shared
    // Main sequence; unused peripheral inputs stay quiet.
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
        wdata = 32'h0; wstrb = 4'h0; ext_irq0_n = 1'b1; ext_irq1_n = 1'b1;
        ext_irq_hi_n = 4'hf; periph_flags = 22'h0; serial_rx_flag = 1'b0;
        serial_tx_flag = 1'b0; timer2_overflow_flag = 1'b0; ret_req = 1'b0;
        timer2_external_flag = 1'b0; counter_array_overflow_flag = 1'b0;
        capture_module_flag = 5'h00; mismatches = 0; n_compared = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_edge();
        t_level();
        t_arb();
        t_shared();
        end_of_test();
    end
endmodule : tb_top
